// ===== hdl/sqic_cfg.svh
`ifndef SQIC_CFG_SVH
`define SQIC_CFG_SVH

// Register byte offsets on the Wishbone slave
`define SQIC_SCR_OFS 8'h00
`define SQIC_BCR_OFS 8'h04
`define SQIC_QCR_OFS 8'h08
`define SQIC_FSR_OFS 8'h0c
`define SQIC_RFR0_OFS 8'h10
`define SQIC_IRQ0_ENABLE_OFS 8'h20
`define SQIC_IRQ0_PENDING_OFS 8'h24
`define SQIC_IRQ0_TIMING_OFS 8'h28
`define SQIC_IRQ_STRIDE 8'h0c

// System control fields
`define SQIC_SCR_SLOT_MSB 6
`define SQIC_SCR_START_BIT 8
`define SQIC_SCR_MON_BIT 9
`define SQIC_SCR_LF_BIT 14

// Basic configuration fields
`define SQIC_BCR_NODE_MSB 5
`define SQIC_BCR_OWNW_LSB 8
`define SQIC_BCR_OWNW_MSB 13
`define SQIC_BCR_LFS_BIT 15

// Query control fields
`define SQIC_QCR_TGT_MSB 5
`define SQIC_QCR_PEND_BIT 6
`define SQIC_QCR_TYPE_LSB 8
`define SQIC_QCR_TYPE_MSB 12

// Last slot, frame and interrupt figures
`define SQIC_FSR_RESET 6'h3f
`define SQIC_LONG_FRAME_LEN 9'h100
`define SQIC_ALM_MSB 6
`define SQIC_DR_LSB 8
`define SQIC_DR_MSB 14
`define SQIC_RETRIG_CLKS 3'h5

`endif

// ===== hdl/sqic_pkg.sv
package sqic_pkg;
    typedef logic [15:0] sqic_word_t;
    // Peer type codes returned by a mode query
    typedef enum logic [4:0] {
        SQIC_TC_MEM = 5'h00,
        SQIC_TC_MEM_LF = 5'h01,
        SQIC_TC_IO = 5'h02,
        SQIC_TC_IO_LF = 5'h03,
        SQIC_TC_MEM_OWNX = 5'h04
    } sqic_type_t;
endpackage

// ===== hdl/sqic_top.sv
// The Wishbone slave port and the address map were chosen for this implementation.
`include "sqic_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module sqic_top #(
    parameter logic [8:0] NORMAL_FRAME_LEN = 9'h080
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Cycle engine status, same clock
    input wire logic [6:0] SLOT_TIME_INDEX,
    input wire logic [5:0] LAST_SLOT_FIELD,
    input wire logic GM_CHANGE,
    // Packet receive report, same clock
    input wire logic PKT_RX_VALID,
    input wire logic [5:0] PKT_RX_NODE,
    input wire logic PKT_RX_LONG_FRAME,
    // Mode query handshake with the link engine
    output logic QUERY_REQ,
    output logic [5:0] QUERY_NODE,
    input wire logic QUERY_DONE,
    input wire logic [4:0] QUERY_TYPE,
    // Station settings seen by the link engine
    output logic NET_START,
    output logic LINK_ENABLE,
    output logic [5:0] OWN_NODE,
    output logic [5:0] OWN_WIDTH,
    output logic [8:0] FRAME_LENGTH,
    output logic [4:0] OWN_TYPE_CODE,
    output logic PING_INHIBIT,
    output logic CYCLE_RESIZED,
    // Decoded peer type
    output logic PEER_IS_IO,
    output logic PEER_LONG_FRAME,
    output logic PEER_CODE_RESERVED,
    // Other interrupt factors, bits 2 to 15 used
    input wire logic [15:0] IRQ_EVENTS,
    // Interrupt pins
    output logic IRQ0_N_PIN,
    output logic IRQ1_N_PIN
);

    // Byte-lane merge of a write into a 16-bit register
    function automatic sqic_pkg::sqic_word_t lane_merge(
        input sqic_pkg::sqic_word_t old_val,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        sqic_pkg::sqic_word_t mask;
        mask = {{8{sel[1]}}, {8{sel[0]}}};
        lane_merge = (old_val & ~mask) | (wdat[15:0] & mask);
    endfunction

    // Word index of a byte offset
    function automatic logic [5:0] word_idx(input logic [7:0] ofs);
        word_idx = ofs[7:2];
    endfunction

    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Reset released through two flops; async assert only
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Bus decode; writes land on the edge where ack is seen
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic bus_req;
    logic wr_stb;
    logic [5:0] idx;
    assign bus_req = WB_CYC_I & WB_STB_I;
    assign wr_stb = bus_req & WB_WE_I & ack_reg;
    assign idx = WB_ADR_I[7:2];

    logic wr_scr;
    logic wr_bcr;
    logic wr_qcr;
    assign wr_scr = wr_stb && (idx == word_idx(`SQIC_SCR_OFS));
    assign wr_bcr = wr_stb && (idx == word_idx(`SQIC_BCR_OFS));
    assign wr_qcr = wr_stb && (idx == word_idx(`SQIC_QCR_OFS));

    // Control registers
    logic start_reg;
    logic monitor_only_mode_reg;
    logic long_frame_active_reg;
    sqic_pkg::sqic_word_t basic_config_reg;
    logic [5:0] query_target_addr_reg;
    logic query_pending_reg;
    logic [4:0] peer_type_code_reg;
    logic [5:0] last_slot_reg;
    logic [63:0] receive_seen_flags_reg;
    logic [6:0] slot_prev_reg;

    sqic_pkg::sqic_word_t scr_wval;
    sqic_pkg::sqic_word_t bcr_wval;
    sqic_pkg::sqic_word_t qcr_wval;
    assign scr_wval = lane_merge(16'h0000, WB_DAT_I, WB_SEL_I);
    assign bcr_wval = lane_merge(basic_config_reg, WB_DAT_I, WB_SEL_I);
    assign qcr_wval = lane_merge({3'h0, peer_type_code_reg, 1'b0, query_pending_reg, query_target_addr_reg},
                                 WB_DAT_I, WB_SEL_I);

    logic start_next;
    logic monitor_next;
    logic link_en;
    logic lf_request;
    logic lf_set;
    logic query_set;
    logic query_abort;
    logic query_fin;
    assign start_next = wr_scr ? scr_wval[`SQIC_SCR_START_BIT] : start_reg;
    // Monitor can only be entered while stopped; leaving is always allowed
    assign monitor_next = !wr_scr ? monitor_only_mode_reg :
                          (!scr_wval[`SQIC_SCR_MON_BIT] ? 1'b0 :
                          (start_reg ? monitor_only_mode_reg : 1'b1));
    assign link_en = start_reg & ~monitor_only_mode_reg;
    assign lf_request = basic_config_reg[`SQIC_BCR_LFS_BIT];
    // Own request at start, or adopted from any linked long-frame peer
    assign lf_set = (start_reg & lf_request) | (link_en & PKT_RX_VALID & PKT_RX_LONG_FRAME);
    assign query_set = wr_qcr & qcr_wval[`SQIC_QCR_PEND_BIT];
    assign query_abort = wr_qcr & ~qcr_wval[`SQIC_QCR_PEND_BIT];
    // No answer from an absent node means pending drops only on a query control write
    assign query_fin = query_pending_reg & QUERY_DONE;

    // System and basic configuration state
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 1'b0;
            monitor_only_mode_reg <= 1'b0;
            basic_config_reg <= 16'h0000;
        end else begin
            start_reg <= start_next;
            monitor_only_mode_reg <= monitor_next;
            basic_config_reg <= wr_bcr ? bcr_wval : basic_config_reg;
        end
    end

    // Long frame flag is sticky until hardware reset
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            long_frame_active_reg <= 1'b0;
        end else begin
            long_frame_active_reg <= long_frame_active_reg | lf_set;
        end
    end

    // Query engine; a new request wins over a completion in the same cycle
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            query_target_addr_reg <= 6'h00;
            query_pending_reg <= 1'b0;
            peer_type_code_reg <= 5'h00;
        end else begin
            if (wr_qcr) begin
                query_target_addr_reg <= qcr_wval[`SQIC_QCR_TGT_MSB:0];
            end
            if (query_set) begin
                query_pending_reg <= 1'b1;
            end else if (query_abort || query_fin) begin
                query_pending_reg <= 1'b0;
            end
            if (query_fin) begin
                peer_type_code_reg <= QUERY_TYPE;
            end
        end
    end

    // Receive flags: wiped at slot zero, then rebuilt from arrivals
    logic [63:0] rx_hit;
    logic [63:0] rfr_next;
    assign rx_hit = PKT_RX_VALID ? (64'h1 << PKT_RX_NODE) : 64'h0;
    assign rfr_next = ((SLOT_TIME_INDEX == 7'h00) ? 64'h0 : receive_seen_flags_reg) | rx_hit;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            receive_seen_flags_reg <= 64'h0;
            last_slot_reg <= `SQIC_FSR_RESET;
            slot_prev_reg <= 7'h00;
        end else begin
            receive_seen_flags_reg <= rfr_next;
            last_slot_reg <= LAST_SLOT_FIELD;
            slot_prev_reg <= SLOT_TIME_INDEX;
        end
    end

    // Slot-time events shared by both interrupt channels
    logic slot_step;
    assign slot_step = SLOT_TIME_INDEX != slot_prev_reg;

    // Two identical interrupt channels with their own registers
    logic [15:0] irq_rd [2];
    logic [1:0] irq_hit;
    logic [1:0] irq_n;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_irq
            localparam int BASE = `SQIC_IRQ0_ENABLE_OFS + ch * `SQIC_IRQ_STRIDE;
            localparam logic [5:0] EN_IDX = 6'(BASE / 4);
            localparam logic [5:0] PEND_IDX = 6'((BASE + 4) / 4);
            localparam logic [5:0] TIM_IDX = 6'((BASE + 8) / 4);

            sqic_pkg::sqic_word_t en_reg;
            sqic_pkg::sqic_word_t pend_reg;
            sqic_pkg::sqic_word_t tim_reg;
            logic [2:0] retrig_reg;
            logic irq_n_reg;

            sqic_pkg::sqic_word_t ev;
            sqic_pkg::sqic_word_t clr;
            sqic_pkg::sqic_word_t pend_next;
            logic [2:0] retrig_next;
            logic alarm_irq;
            logic gm_change_irq;
            logic clr_hit;

            assign alarm_irq = slot_step && (SLOT_TIME_INDEX == tim_reg[`SQIC_ALM_MSB:0]);
            assign gm_change_irq = slot_step && GM_CHANGE &&
                                   (SLOT_TIME_INDEX == tim_reg[`SQIC_DR_MSB:`SQIC_DR_LSB]);
            assign ev = {IRQ_EVENTS[15:2], gm_change_irq, alarm_irq};
            assign clr = (wr_stb && idx == PEND_IDX) ? lane_merge(16'h0000, WB_DAT_I, WB_SEL_I) : 16'h0000;
            // New factor wins over a clear of the same bit; enable not consulted for hold
            assign pend_next = (pend_reg & ~clr) | (ev & en_reg);
            assign clr_hit = |(pend_reg & clr);
            // A clear that leaves work behind forces a high gap for edge-triggered CPUs
            assign retrig_next = (clr_hit && |pend_next) ? `SQIC_RETRIG_CLKS :
                                 ((retrig_reg != 3'h0) ? retrig_reg - 3'h1 : 3'h0);

            always_ff @(posedge MCLK or negedge rst_n) begin
                if (!rst_n) begin
                    en_reg <= 16'h0000;
                    pend_reg <= 16'h0000;
                    tim_reg <= 16'h0000;
                    retrig_reg <= 3'h0;
                    irq_n_reg <= 1'b1;
                end else begin
                    en_reg <= (wr_stb && idx == EN_IDX) ? lane_merge(en_reg, WB_DAT_I, WB_SEL_I) : en_reg;
                    tim_reg <= (wr_stb && idx == TIM_IDX) ? lane_merge(tim_reg, WB_DAT_I, WB_SEL_I) : tim_reg;
                    pend_reg <= pend_next;
                    retrig_reg <= retrig_next;
                    irq_n_reg <= ~(|pend_next) | (retrig_next != 3'h0);
                end
            end

            assign irq_hit[ch] = (idx == EN_IDX) || (idx == PEND_IDX) || (idx == TIM_IDX);
            assign irq_rd[ch] = (idx == EN_IDX) ? en_reg :
                                (idx == PEND_IDX) ? pend_reg :
                                (idx == TIM_IDX) ? {1'b0, tim_reg[14:8], 1'b0, tim_reg[6:0]} : 16'h0000;
            assign irq_n[ch] = irq_n_reg;
        end
    endgenerate

    // Register read selection; unmapped words read zero
    sqic_pkg::sqic_word_t scr_rd;
    sqic_pkg::sqic_word_t qcr_rd;
    sqic_pkg::sqic_word_t rfr_rd;
    logic rfr_sel;
    logic [1:0] rfr_word;
    assign scr_rd = {1'b0, long_frame_active_reg, 4'h0, monitor_only_mode_reg, start_reg,
                     1'b0, SLOT_TIME_INDEX};
    assign qcr_rd = {3'h0, peer_type_code_reg, 1'b0, query_pending_reg, query_target_addr_reg};
    assign rfr_sel = idx[5:2] == word_idx(`SQIC_RFR0_OFS) >> 2;
    assign rfr_word = idx[1:0];
    assign rfr_rd = receive_seen_flags_reg[{rfr_word, 4'h0} +: 16];
    assign rdat_next[31:16] = 16'h0000;
    assign rdat_next[15:0] = (idx == word_idx(`SQIC_SCR_OFS)) ? scr_rd :
                             (idx == word_idx(`SQIC_BCR_OFS)) ? basic_config_reg :
                             (idx == word_idx(`SQIC_QCR_OFS)) ? qcr_rd :
                             (idx == word_idx(`SQIC_FSR_OFS)) ? {10'h000, last_slot_reg} :
                             rfr_sel ? rfr_rd :
                             irq_hit[0] ? irq_rd[0] :
                             irq_hit[1] ? irq_rd[1] : 16'h0000;

    // One wait state: data captured in the request cycle, ack the next
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            rdat_reg <= (bus_req & ~ack_reg) ? rdat_next : rdat_reg;
        end
    end

    // Peer type decoding for the last answered query
    function automatic logic [2:0] type_decode(input logic [4:0] code);
        case (code)
            sqic_pkg::SQIC_TC_MEM: type_decode = 3'h0;
            sqic_pkg::SQIC_TC_MEM_LF: type_decode = 3'h2;
            sqic_pkg::SQIC_TC_IO: type_decode = 3'h4;
            sqic_pkg::SQIC_TC_IO_LF: type_decode = 3'h6;
            sqic_pkg::SQIC_TC_MEM_OWNX: type_decode = 3'h0;
            default: type_decode = 3'h1;
        endcase
    endfunction

    logic [2:0] peer_dec;
    assign peer_dec = type_decode(peer_type_code_reg);

    // Outputs
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;
    assign QUERY_REQ = query_pending_reg;
    assign QUERY_NODE = query_target_addr_reg;
    assign PING_INHIBIT = query_pending_reg;
    assign NET_START = start_reg;
    assign LINK_ENABLE = link_en;
    // Monitor station has no owned area; settings are masked out
    assign OWN_NODE = monitor_only_mode_reg ? 6'h00 : basic_config_reg[`SQIC_BCR_NODE_MSB:0];
    assign OWN_WIDTH = monitor_only_mode_reg ? 6'h00 :
                       basic_config_reg[`SQIC_BCR_OWNW_MSB:`SQIC_BCR_OWNW_LSB];
    assign FRAME_LENGTH = long_frame_active_reg ? `SQIC_LONG_FRAME_LEN : NORMAL_FRAME_LEN;
    assign OWN_TYPE_CODE = long_frame_active_reg ? sqic_pkg::SQIC_TC_MEM_LF : sqic_pkg::SQIC_TC_MEM;
    // Resize and long frame together is unsupported; nothing here arbitrates it
    assign CYCLE_RESIZED = last_slot_reg != `SQIC_FSR_RESET;
    assign PEER_IS_IO = peer_dec[2];
    assign PEER_LONG_FRAME = peer_dec[1];
    assign PEER_CODE_RESERVED = peer_dec[0];
    assign IRQ0_N_PIN = irq_n[0];
    assign IRQ1_N_PIN = irq_n[1];

endmodule

`default_nettype wire

// ===== dv/sqic_checker.sv
`timescale 1ns/1ns
`default_nettype none

module sqic_checker #(
    parameter logic [8:0] NORMAL_FRAME_LEN = 9'h080
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Bus answer
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic WB_ACK_O,
    // Query link
    input wire logic QUERY_REQ,
    input wire logic QUERY_DONE,
    input wire logic [4:0] QUERY_TYPE,
    input wire logic PING_INHIBIT,
    input wire logic PEER_CODE_RESERVED,
    // Station settings
    input wire logic [5:0] LAST_SLOT_FIELD,
    input wire logic CYCLE_RESIZED,
    input wire logic [8:0] FRAME_LENGTH,
    input wire logic [4:0] OWN_TYPE_CODE,
    // Interrupt pin
    input wire logic IRQ0_N_PIN
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    // Acked writes, the only moment a write lands
    wire logic qcr_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h08;
    wire logic en_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h20;
    wire logic sr_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h24;

    chk_query_done_clear: assert property (
        QUERY_REQ && QUERY_DONE && !qcr_wr |=> !QUERY_REQ) else $error("pending not cleared");
    chk_absent_holds: assert property (
        QUERY_REQ && !QUERY_DONE && !qcr_wr |=> QUERY_REQ) else $error("pending lost");
    chk_ping_blocked: assert property (
        PING_INHIBIT == QUERY_REQ) else $error("ping block wrong");
    chk_code_decode: assert property (
        QUERY_REQ && QUERY_DONE |=> PEER_CODE_RESERVED == ($past(QUERY_TYPE) > 5'h04)) else $error("bad decode");
    chk_resize_flag: assert property (
        CYCLE_RESIZED == ($past(LAST_SLOT_FIELD) != 6'h3f)) else $error("resize flag wrong");
    chk_frame_len: assert property (
        FRAME_LENGTH == (OWN_TYPE_CODE == 5'h01 ? 9'h100 : NORMAL_FRAME_LEN)) else $error("frame length wrong");
    chk_long_sticky: assert property (
        FRAME_LENGTH == 9'h100 |=> FRAME_LENGTH == 9'h100) else $error("long frame dropped");
    chk_irq_release: assert property (
        $rose(IRQ0_N_PIN) |-> $past(sr_wr) || $past(sr_wr, 2)) else $error("pin rose without clear");
    chk_read_keeps: assert property (
        WB_ACK_O && !WB_WE_I && !IRQ0_N_PIN |=> !IRQ0_N_PIN) else $error("read released pin");
    chk_disable_keeps: assert property (
        en_wr && !IRQ0_N_PIN |=> !IRQ0_N_PIN) else $error("enable write released pin");
endmodule

`default_nettype wire

// ===== dv/sqic_link_model.sv
`timescale 1ns/1ns
`default_nettype none

module sqic_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Query handshake
    input wire logic query_req,
    input wire logic [5:0] query_node,
    output logic query_done,
    output logic [4:0] query_type
);
    logic [2:0] cnt;

    // Peer answers after node[2:0] cycles; type code is node[4:0]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            query_done <= 1'b0;
            query_type <= 5'h15;
            cnt <= 3'h0;
        end else begin
            query_done <= 1'b0;
            query_type <= ~query_type; // Idle lane toggles so no stale code is held steady
            if (query_req && !query_done && !query_node[5]) begin // Nodes 32 up absent
                if (cnt == query_node[2:0]) begin
                    query_done <= 1'b1;
                    query_type <= query_node[4:0];
                    cnt <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end else begin
                cnt <= 3'h0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== dv/station_query_irq_control_tb.sv
`timescale 1ns/1ns
`default_nettype none

module station_query_irq_control_tb;
    localparam logic [8:0] NFL = 9'h080;
    logic MCLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, GM_CHANGE, PKT_RX_VALID, PKT_RX_LONG_FRAME;
    logic QUERY_REQ, QUERY_DONE, NET_START, LINK_ENABLE, PING_INHIBIT, CYCLE_RESIZED, IRQ0_N_PIN, IRQ1_N_PIN;
    logic PEER_IS_IO, PEER_LONG_FRAME, PEER_CODE_RESERVED;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic [7:0] WB_ADR_I;
    logic [6:0] SLOT_TIME_INDEX;
    logic [5:0] LAST_SLOT_FIELD, PKT_RX_NODE, QUERY_NODE, OWN_NODE, OWN_WIDTH;
    logic [4:0] QUERY_TYPE, OWN_TYPE_CODE;
    logic [8:0] FRAME_LENGTH;
    logic [15:0] IRQ_EVENTS, q;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    sqic_top #(.NORMAL_FRAME_LEN(NFL)) i_dut (.MCLK(MCLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'h3), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O), .SLOT_TIME_INDEX(SLOT_TIME_INDEX), .LAST_SLOT_FIELD(LAST_SLOT_FIELD),
        .GM_CHANGE(GM_CHANGE), .PKT_RX_VALID(PKT_RX_VALID), .PKT_RX_NODE(PKT_RX_NODE),
        .PKT_RX_LONG_FRAME(PKT_RX_LONG_FRAME), .QUERY_REQ(QUERY_REQ), .QUERY_NODE(QUERY_NODE),
        .QUERY_DONE(QUERY_DONE), .QUERY_TYPE(QUERY_TYPE), .NET_START(NET_START), .LINK_ENABLE(LINK_ENABLE),
        .OWN_NODE(OWN_NODE), .OWN_WIDTH(OWN_WIDTH), .FRAME_LENGTH(FRAME_LENGTH), .OWN_TYPE_CODE(OWN_TYPE_CODE),
        .PING_INHIBIT(PING_INHIBIT), .CYCLE_RESIZED(CYCLE_RESIZED), .PEER_IS_IO(PEER_IS_IO),
        .PEER_LONG_FRAME(PEER_LONG_FRAME), .PEER_CODE_RESERVED(PEER_CODE_RESERVED), .IRQ_EVENTS(IRQ_EVENTS),
        .IRQ0_N_PIN(IRQ0_N_PIN), .IRQ1_N_PIN(IRQ1_N_PIN));
    sqic_link_model i_link (.clk(MCLK), .rst_n(NRST), .query_req(QUERY_REQ), .query_node(QUERY_NODE),
        .query_done(QUERY_DONE), .query_type(QUERY_TYPE));

    // Clock and hang guard
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // One classic cycle; the edge that sees ack takes data, then one idle cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= {16'h0000, d};
        do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
        r = WB_DAT_O[15:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        tick(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        wb(a, 1'b0, 16'h0000, q);
        check(q, e);
    endtask
    task automatic slots(input int n);
        for (int i = 0; i < n; i++) begin
            SLOT_TIME_INDEX <= 7'(i);
            tick(1);
        end
    endtask
    task automatic pkt(input logic [5:0] nd, input logic lf);
        PKT_RX_VALID <= 1'b1;
        PKT_RX_NODE <= nd;
        PKT_RX_LONG_FRAME <= lf;
        tick(1);
        PKT_RX_VALID <= 1'b0;
        tick(1);
    endtask
    task automatic do_reset();
        NRST <= 1'b0;
        tick(16);
        NRST <= 1'b1;
        tick(4);
    endtask

    task automatic t_regs();
        rd(8'h20, 16'h0000);
        rd(8'h0c, 16'h003f);
        rd(8'h3c, 16'h0000);
        wr(8'h28, 16'hffff);
        rd(8'h28, 16'h7f7f);
        LAST_SLOT_FIELD <= 6'h20; // Resize only while long frame is off
        tick(2);
        check(CYCLE_RESIZED, 1'b1);
        rd(8'h0c, 16'h0020);
        LAST_SLOT_FIELD <= 6'h3f;
        $display("regs done");
    endtask
    // Every defined code and two reserved (05 and 1f), prompt and slow peers
    task automatic t_query();
        logic [5:0] nd;
        for (int i = 0; i < 7; i++) begin
            nd = (i == 6) ? 6'h1f : 6'(i);
            wr(8'h08, 16'h0040 | 16'(nd));
            q = 16'h0040;
            for (int k = 0; k < 20 && q[6] !== 1'b0; k++) wb(8'h08, 1'b0, 16'h0000, q);
            check(q, {3'h0, nd[4:0], 2'h0, nd});
            check({PEER_IS_IO, PEER_LONG_FRAME, PEER_CODE_RESERVED},
                {nd[4:1] == 4'h1, nd[4:2] == 3'h0 && nd[0], nd > 6'h04});
        end
        wr(8'h08, 16'h0060);
        tick(40);
        check({QUERY_REQ, PING_INHIBIT}, 2'b11);
        check(QUERY_NODE, 6'h20);
        rd(8'h08, 16'h1f60);
        $display("query done");
    endtask
    // Runs with the absent query still pending
    task automatic t_irq();
        int n;
        n = 0;
        wr(8'h20, 16'h1004);
        wr(8'h2c, 16'h1000);
        IRQ_EVENTS <= 16'h100c;
        tick(1);
        IRQ_EVENTS <= 16'h0000;
        tick(1);
        check({IRQ0_N_PIN, IRQ1_N_PIN}, 2'b00);
        rd(8'h30, 16'h1000);
        rd(8'h24, 16'h1004);
        rd(8'h24, 16'h1004);
        wr(8'h20, 16'h0000);
        rd(8'h24, 16'h1004);
        wr(8'h24, 16'h0004);
        for (int k = 0; k < 10; k++) begin
            n = n + int'(IRQ0_N_PIN === 1'b1);
            tick(1);
        end
        check(n, 5);
        check(IRQ0_N_PIN, 1'b0);
        rd(8'h24, 16'h1000);
        wr(8'h30, 16'h1000);
        wr(8'h24, 16'h1000);
        tick(3);
        check({IRQ0_N_PIN, IRQ1_N_PIN}, 2'b11);
        rd(8'h24, 16'h0000);
        wr(8'h08, 16'h0020);
        rd(8'h08, 16'h1f20);
        $display("irq done");
    endtask
    task automatic t_timing();
        wr(8'h28, 16'h2010);
        wr(8'h20, 16'h0003);
        slots(48);
        rd(8'h24, 16'h0001);
        GM_CHANGE <= 1'b1;
        slots(48);
        rd(8'h24, 16'h0003);
        GM_CHANGE <= 1'b0;
        wr(8'h24, 16'h0003);
        wr(8'h20, 16'h0000);
        $display("timing done");
    endtask
    task automatic t_monitor();
        wr(8'h04, 16'h0d05);
        check({OWN_NODE, OWN_WIDTH}, 12'h14d);
        wr(8'h00, 16'h0200);
        rd(8'h00, 16'h022f);
        check({LINK_ENABLE, OWN_NODE, OWN_WIDTH}, 13'h0000);
        slots(4);
        pkt(6'h02, 1'b1);
        pkt(6'h11, 1'b0);
        rd(8'h10, 16'h0004);
        rd(8'h14, 16'h0002);
        slots(1);
        rd(8'h10, 16'h0000);
        rd(8'h00, 16'h0200);
        wr(8'h00, 16'h0100);
        wr(8'h00, 16'h0300);
        rd(8'h00, 16'h0100);
        check({NET_START, LINK_ENABLE}, 2'b11);
        $display("monitor done");
    endtask
    task automatic t_long();
        // Long frame is requested while stopped, then the network starts
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h8000);
        check(FRAME_LENGTH, NFL);
        wr(8'h00, 16'h0100);
        tick(2);
        check({FRAME_LENGTH, OWN_TYPE_CODE}, {9'h100, 5'h01});
        rd(8'h00, 16'h4100);
        wr(8'h04, 16'h0000);
        wr(8'h00, 16'h0000);
        rd(8'h00, 16'h4000);
        do_reset();
        rd(8'h00, 16'h0000);
        check(FRAME_LENGTH, NFL);
        wr(8'h00, 16'h0100);
        pkt(6'h09, 1'b1);
        rd(8'h00, 16'h4100);
        $display("long frame done");
    endtask

    initial begin
        {NRST, WB_CYC_I, WB_STB_I, WB_WE_I, GM_CHANGE, PKT_RX_VALID, PKT_RX_LONG_FRAME} = 7'h00;
        WB_ADR_I = 8'h00;
        WB_DAT_I = 32'h0;
        SLOT_TIME_INDEX = 7'h00;
        LAST_SLOT_FIELD = 6'h3f;
        PKT_RX_NODE = 6'h00;
        IRQ_EVENTS = 16'h0000;
        do_reset();
        t_regs();
        t_query();
        t_irq();
        t_timing();
        t_monitor();
        t_long();
        final_report();
    end
endmodule

bind sqic_top sqic_checker #(.NORMAL_FRAME_LEN(NORMAL_FRAME_LEN)) i_chk (.MCLK(MCLK), .NRST(NRST),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .QUERY_REQ(QUERY_REQ), .QUERY_DONE(QUERY_DONE),
    .QUERY_TYPE(QUERY_TYPE), .PING_INHIBIT(PING_INHIBIT), .PEER_CODE_RESERVED(PEER_CODE_RESERVED),
    .LAST_SLOT_FIELD(LAST_SLOT_FIELD), .CYCLE_RESIZED(CYCLE_RESIZED), .FRAME_LENGTH(FRAME_LENGTH),
    .OWN_TYPE_CODE(OWN_TYPE_CODE), .IRQ0_N_PIN(IRQ0_N_PIN));

`default_nettype wire
